// ==== hdl/pfs_pkg.sv ====
package pfs_pkg;
  localparam int PFS_GROUPS = 7;
  localparam int PFS_GW = 8;
  localparam int PFS_PINS = 56;
  localparam int PFS_ADDR_LSB = 2;
  localparam int PFS_IDX_W = 30;
  localparam logic [29:0] IDX_G8 = 30'h00800748;
  localparam logic [29:0] IDX_G9 = 30'h00800749;
  localparam logic [29:0] IDX_G10 = 30'h0080074a;
  localparam logic [29:0] IDX_G11 = 30'h0080074b;
  localparam logic [29:0] IDX_G12 = 30'h0080074c;
  localparam logic [29:0] IDX_G13 = 30'h0080074d;
  localparam logic [29:0] IDX_G15 = 30'h0080074f;
  localparam logic [2:0] GRP_G8 = 3'h0;
  localparam logic [2:0] GRP_G9 = 3'h1;
  localparam logic [2:0] GRP_G10 = 3'h2;
  localparam logic [2:0] GRP_G11 = 3'h3;
  localparam logic [2:0] GRP_G12 = 3'h4;
  localparam logic [2:0] GRP_G13 = 3'h5;
  localparam logic [2:0] GRP_G15 = 3'h6;
  localparam logic [7:0] SEL_RESET = 8'h00;
  // Implemented pins, group 15 in the top byte, group 8 in the bottom
  localparam logic [55:0] IMPL_MASK = 56'h09_ff_f0_ff_ff_f8_fc;
  localparam int SLOT_TX0 = 2;
  localparam int SLOT_RX0 = 3;
  localparam int SLOT_CK0 = 4;
  localparam int SLOT_TX1 = 5;
  localparam int SLOT_RX1 = 6;
  localparam int SLOT_CK1 = 7;
  localparam int SLOT_TIMER_OUTPUT_16 = 11;
  localparam int TO_G9_FIRST = 16;
  localparam int TO_G9_N = 5;
  localparam int SLOT_TO8 = 16;
  localparam int TO_G10_FIRST = 8;
  localparam int SLOT_TO0 = 24;
  localparam int TO_G11_FIRST = 0;
  localparam int TO_BYTE_N = 8;
  localparam int SLOT_TIMER_CLOCK_INPUT_0 = 36;
  localparam int TCLK_N = 4;
  localparam int SLOT_TIMER_INPUT_16 = 40;
  localparam int TIN_G13_FIRST = 16;
  localparam int TIN_G13_N = 8;
  localparam int SLOT_TIMER_INPUT_0 = 48;
  localparam int SLOT_TIMER_INPUT_3 = 51;
  localparam int TIN_A = 0;
  localparam int TIN_B = 3;
  localparam int TIMER_OUT_N = 21;
  localparam int TIMER_IN_N = 24;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [23:0] RD_PAD = 24'h000000;
endpackage : pfs_pkg

// ==== hdl/pfs_sync2.sv ====
`timescale 1ns/1ns
module pfs_sync2
  import pfs_pkg::*;
#(
  parameter int W = PFS_PINS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q_ff
);
  logic [W-1:0] stage1_ff;

  // Two flops before any logic looks at the pads
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage1_ff <= '0;
      q_ff <= '0;
    end else begin
      stage1_ff <= d;
      q_ff <= stage1_ff;
    end
  end
endmodule : pfs_sync2

// ==== hdl/pfs_pin_cell.sv ====
`timescale 1ns/1ns
module pfs_pin_cell
  import pfs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sel,
  input wire logic port_out,
  input wire logic port_dir,
  input wire logic per_out,
  input wire logic per_oe,
  input wire logic pad_sync,
  output logic pad_out_ff,
  output logic pad_oe_ff,
  output logic per_in_ff,
  output logic port_in_ff
);
  // Peripheral or port owns the pad, switched at the next edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pad_out_ff <= 1'b0;
      pad_oe_ff <= 1'b0;
      per_in_ff <= 1'b0;
      port_in_ff <= 1'b0;
    end else begin
      pad_out_ff <= sel ? per_out : port_out;
      pad_oe_ff <= sel ? per_oe : port_dir;
      per_in_ff <= sel ? pad_sync : 1'b0;
      port_in_ff <= pad_sync;
    end
  end
endmodule : pfs_pin_cell

// ==== hdl/pfs_top.sv ====
// Notes on behaviour
// - Group 8 bits 2-4 select serial 0
// - Group 8 bits 5-7 select serial 1
// - Group 9 bits 11-15 select timer outputs 16-20
// - Group 10 bits 0-7 select timer outputs 8-15
// - Group 11 bits 8-15 select timer outputs 0-7
// - Group 12 bits 4-7 select timer clocks 0-3
// - Group 13 bits 8-15 select timer inputs 16-23
// - Group 15 bits 8, 11 select timer inputs 0, 3
// - Group 8 bits 0-1 read zero, ignore writes
// - Group 9 bits 8-10 read zero, ignore writes
// - Group 12 bits 0-3 read zero, ignore writes
// - Group 15 bits 9,10,12-15 read zero, ignore writes
// - Unselected existing pin direction follows port direction bit
`timescale 1ns/1ns
module pfs_top
  import pfs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [55:0] pad_in,
  output logic [55:0] pad_out,
  output logic [55:0] pad_oe,
  input wire logic [55:0] port_data_out,
  input wire logic [55:0] port_dir,
  output logic [55:0] port_data_in,
  input wire logic serial0_transmit,
  output logic serial0_receive,
  output logic serial0_clock_in,
  input wire logic serial0_clock_out,
  input wire logic serial0_clock_oe,
  input wire logic serial1_transmit,
  output logic serial1_receive,
  output logic serial1_clock_in,
  input wire logic serial1_clock_out,
  input wire logic serial1_clock_oe,
  input wire logic [20:0] timer_output,
  output logic [3:0] timer_clock_input,
  output logic [23:0] timer_input
);
  logic [7:0] sel_ff [PFS_GROUPS];
  logic [55:0] sel_vec;
  logic [55:0] pad_sync;
  logic [55:0] per_out_vec;
  logic [55:0] per_oe_vec;
  logic [55:0] per_in_vec;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;
  logic aw_hold_ff;
  logic w_hold_ff;
  logic [29:0] aw_idx_ff;
  logic [7:0] wdata_ff;
  logic wstrb_ff;
  logic aw_fire;
  logic w_fire;
  logic b_fire;
  logic ar_fire;
  logic r_fire;
  logic do_write;
  logic [3:0] wr_dec;
  logic [3:0] rd_dec;

  // Index to {hit, group}
  function automatic logic [3:0] pfs_decode(input logic [29:0] idx);
    logic [3:0] res;
    res = 4'h0;
    if (idx == IDX_G8) begin
      res = {1'b1, GRP_G8};
    end else if (idx == IDX_G9) begin
      res = {1'b1, GRP_G9};
    end else if (idx == IDX_G10) begin
      res = {1'b1, GRP_G10};
    end else if (idx == IDX_G11) begin
      res = {1'b1, GRP_G11};
    end else if (idx == IDX_G12) begin
      res = {1'b1, GRP_G12};
    end else if (idx == IDX_G13) begin
      res = {1'b1, GRP_G13};
    end else if (idx == IDX_G15) begin
      res = {1'b1, GRP_G15};
    end
    return res;
  endfunction : pfs_decode

  assign aw_fire = s_axi_awvalid && awready_ff;
  assign w_fire = s_axi_wvalid && wready_ff;
  assign b_fire = bvalid_ff && s_axi_bready;
  assign ar_fire = s_axi_arvalid && arready_ff;
  assign r_fire = rvalid_ff && s_axi_rready;
  assign do_write = aw_hold_ff && w_hold_ff && !bvalid_ff;
  assign wr_dec = pfs_decode(aw_idx_ff);
  assign rd_dec = pfs_decode(s_axi_araddr[31:PFS_ADDR_LSB]);

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;

  // Write address capture
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      awready_ff <= 1'b0;
      aw_hold_ff <= 1'b0;
      aw_idx_ff <= '0;
    end else begin
      awready_ff <= !aw_fire && !aw_hold_ff && !bvalid_ff;
      if (aw_fire) begin
        aw_hold_ff <= 1'b1;
        aw_idx_ff <= s_axi_awaddr[31:PFS_ADDR_LSB];
      end else if (b_fire) begin
        aw_hold_ff <= 1'b0;
      end
    end
  end

  // Write data capture
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wready_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      wdata_ff <= SEL_RESET;
      wstrb_ff <= 1'b0;
    end else begin
      wready_ff <= !w_fire && !w_hold_ff && !bvalid_ff;
      if (w_fire) begin
        w_hold_ff <= 1'b1;
        wdata_ff <= s_axi_wdata[7:0];
        wstrb_ff <= s_axi_wstrb[0];
      end else if (b_fire) begin
        w_hold_ff <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_dec[3] ? RESP_OKAY : RESP_SLVERR;
    end else if (b_fire) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Selector registers; absent pins never store a one
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int g = 0; g < PFS_GROUPS; g++) begin
        sel_ff[g] <= SEL_RESET;
      end
    end else if (do_write && wr_dec[3] && wstrb_ff) begin
      for (int g = 0; g < PFS_GROUPS; g++) begin
        if (wr_dec[2:0] == g[2:0]) begin
          sel_ff[g] <= wdata_ff & IMPL_MASK[g*PFS_GW +: PFS_GW];
        end
      end
    end
  end

  // Read channel
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= '0;
    end else begin
      arready_ff <= !ar_fire && !rvalid_ff;
      if (ar_fire) begin
        rvalid_ff <= 1'b1;
        if (rd_dec[3]) begin
          rresp_ff <= RESP_OKAY;
          rdata_ff <= {RD_PAD, sel_ff[rd_dec[2:0]]};
        end else begin
          rresp_ff <= RESP_SLVERR;
          rdata_ff <= '0;
        end
      end else if (r_fire) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  always_comb begin
    for (int g = 0; g < PFS_GROUPS; g++) begin
      sel_vec[g*PFS_GW +: PFS_GW] = sel_ff[g];
    end
  end

  // Peripheral drive toward the pads
  always_comb begin
    per_out_vec = '0;
    per_oe_vec = '0;
    per_out_vec[SLOT_TX0] = serial0_transmit;
    per_oe_vec[SLOT_TX0] = 1'b1;
    per_out_vec[SLOT_CK0] = serial0_clock_out;
    per_oe_vec[SLOT_CK0] = serial0_clock_oe;
    per_out_vec[SLOT_TX1] = serial1_transmit;
    per_oe_vec[SLOT_TX1] = 1'b1;
    per_out_vec[SLOT_CK1] = serial1_clock_out;
    per_oe_vec[SLOT_CK1] = serial1_clock_oe;
    for (int i = 0; i < TO_G9_N; i++) begin
      per_out_vec[SLOT_TIMER_OUTPUT_16+i] = timer_output[TO_G9_FIRST+i];
      per_oe_vec[SLOT_TIMER_OUTPUT_16+i] = 1'b1;
    end
    for (int i = 0; i < TO_BYTE_N; i++) begin
      per_out_vec[SLOT_TO8+i] = timer_output[TO_G10_FIRST+i];
      per_oe_vec[SLOT_TO8+i] = 1'b1;
      per_out_vec[SLOT_TO0+i] = timer_output[TO_G11_FIRST+i];
      per_oe_vec[SLOT_TO0+i] = 1'b1;
    end
  end

  // Pads to peripheral inputs
  assign serial0_receive = per_in_vec[SLOT_RX0];
  assign serial0_clock_in = per_in_vec[SLOT_CK0];
  assign serial1_receive = per_in_vec[SLOT_RX1];
  assign serial1_clock_in = per_in_vec[SLOT_CK1];
  assign timer_clock_input = per_in_vec[SLOT_TIMER_CLOCK_INPUT_0 +: TCLK_N];

  always_comb begin
    timer_input = '0;
    timer_input[TIN_G13_FIRST +: TIN_G13_N] =
      per_in_vec[SLOT_TIMER_INPUT_16 +: TIN_G13_N];
    timer_input[TIN_A] = per_in_vec[SLOT_TIMER_INPUT_0];
    timer_input[TIN_B] = per_in_vec[SLOT_TIMER_INPUT_3];
  end

  pfs_sync2 #(
    .W(PFS_PINS)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .d(pad_in),
    .q_ff(pad_sync)
  );

  // One cell per existing pin; absent pins stay undriven inputs
  for (genvar s = 0; s < PFS_PINS; s++) begin : g_pin
    if (IMPL_MASK[s]) begin : g_cell
      pfs_pin_cell u_cell (
        .ref_clk(ref_clk),
        .rst(rst),
        .sel(sel_vec[s]),
        .port_out(port_data_out[s]),
        .port_dir(port_dir[s]),
        .per_out(per_out_vec[s]),
        .per_oe(per_oe_vec[s]),
        .pad_sync(pad_sync[s]),
        .pad_out_ff(pad_out[s]),
        .pad_oe_ff(pad_oe[s]),
        .per_in_ff(per_in_vec[s]),
        .port_in_ff(port_data_in[s])
      );
    end else begin : g_none
      assign pad_out[s] = 1'b0;
      assign pad_oe[s] = 1'b0;
      assign per_in_vec[s] = 1'b0;
      assign port_data_in[s] = 1'b0;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  AST_G8_RSVD: assert property (sel_ff[GRP_G8][1:0] == 2'b00)
    else $error("group 8 absent bits set");
  AST_G9_RSVD: assert property (sel_ff[GRP_G9][2:0] == 3'b000)
    else $error("group 9 absent bits set");
  AST_G12_RSVD: assert property (sel_ff[GRP_G12][3:0] == 4'h0)
    else $error("group 12 absent bits set");
  AST_G15_RSVD: assert property ((sel_ff[GRP_G15] & 8'hf6) == 8'h00)
    else $error("group 15 absent bits set");
  AST_TX0: assert property (sel_vec[SLOT_TX0] |=>
      pad_oe[SLOT_TX0] && pad_out[SLOT_TX0] == $past(serial0_transmit))
    else $error("serial 0 transmit not on pin");
  AST_RX1: assert property (sel_vec[SLOT_RX1] |=>
      !pad_oe[SLOT_RX1] && serial1_receive == $past(pad_sync[SLOT_RX1]))
    else $error("serial 1 receive not from pin");
  AST_TIMER_OUTPUT_16: assert property (sel_vec[SLOT_TIMER_OUTPUT_16] |=>
      pad_out[SLOT_TIMER_OUTPUT_16] == $past(timer_output[TO_G9_FIRST]))
    else $error("timer output 16 not on pin");
  AST_TO8: assert property (sel_vec[SLOT_TO8] |=>
      pad_out[SLOT_TO8] == $past(timer_output[TO_G10_FIRST]))
    else $error("timer output 8 not on pin");
  AST_TO0: assert property (sel_vec[SLOT_TO0] |=>
      pad_out[SLOT_TO0] == $past(timer_output[TO_G11_FIRST]))
    else $error("timer output 0 not on pin");
  AST_TIMER_CLOCK_INPUT_0: assert property (sel_vec[SLOT_TIMER_CLOCK_INPUT_0] |=>
      timer_clock_input[0] == $past(pad_sync[SLOT_TIMER_CLOCK_INPUT_0]))
    else $error("timer clock 0 not from pin");
  AST_TIMER_INPUT_16: assert property (sel_vec[SLOT_TIMER_INPUT_16] |=>
      timer_input[TIN_G13_FIRST] == $past(pad_sync[SLOT_TIMER_INPUT_16]))
    else $error("timer input 16 not from pin");
  AST_TIMER_INPUT_3: assert property (sel_vec[SLOT_TIMER_INPUT_3] |=>
      timer_input[TIN_B] == $past(pad_sync[SLOT_TIMER_INPUT_3]))
    else $error("timer input 3 not from pin");
  AST_PORT_DIR: assert property (!rst && !sel_vec[SLOT_TO8] |=>
      pad_oe[SLOT_TO8] == $past(port_dir[SLOT_TO8]) &&
      pad_out[SLOT_TO8] == $past(port_data_out[SLOT_TO8]))
    else $error("port direction not followed");
  AST_SWITCH: assert property ($rose(sel_vec[SLOT_TX1]) |=>
      pad_oe[SLOT_TX1] && pad_out[SLOT_TX1] == $past(serial1_transmit))
    else $error("switch to peripheral not on next clock");
  AST_BRESP: assert property (do_write |=> s_axi_bvalid &&
      (s_axi_bresp == RESP_OKAY) == $past(wr_dec[3]))
    else $error("write response wrong");

  COV_WRITE: cover property (b_fire && s_axi_bresp == RESP_OKAY);
  COV_READ: cover property (r_fire && s_axi_rdata[7:0] != 8'h00);
  COV_SWAP: cover property ($rose(sel_vec[SLOT_TO0]) ##1 pad_oe[SLOT_TO0]);
  COV_UNMAPPED: cover property (r_fire && s_axi_rresp == RESP_SLVERR);
endmodule : pfs_top

// ==== tb/pfs_pin_env.sv ====
`timescale 1ns/1ns
module pfs_pin_env
  import pfs_pkg::*;
(
  input wire logic [55:0] pad_out,
  input wire logic [55:0] pad_oe,
  input wire logic [55:0] ext_level,
  output logic [55:0] pad_in
);
  // Driven pins show the device level, others the outside level
  always_comb begin
    for (int i = 0; i < PFS_PINS; i++) begin
      pad_in[i] = pad_oe[i] ? pad_out[i] : ext_level[i];
    end
  end
endmodule : pfs_pin_env

// ==== tb/test_pfs_top.sv ====
`timescale 1ns/1ns
module test_pfs_top
  import pfs_pkg::*;
;
  localparam logic [29:0] RIDX [7] = '{IDX_G8, IDX_G9, IDX_G10, IDX_G11,
    IDX_G12, IDX_G13, IDX_G15};
  localparam logic [55:0] PAT = 56'h96_3c_a5_f0_0f_5a_c3;
  logic ref_clk, rst;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [55:0] pad_in, pad_out, pad_oe, port_data_out, port_dir;
  logic [55:0] port_data_in, ext_level;
  logic serial0_transmit, serial0_receive, serial0_clock_in;
  logic serial0_clock_out, serial0_clock_oe;
  logic serial1_transmit, serial1_receive, serial1_clock_in;
  logic serial1_clock_out, serial1_clock_oe;
  logic [20:0] timer_output;
  logic [3:0] timer_clock_input;
  logic [23:0] timer_input;
  logic [7:0] shadow [7];
  int mismatches, checks_done;

  pfs_top i_dut (.ref_clk, .rst, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .pad_in, .pad_out, .pad_oe, .port_data_out, .port_dir,
    .port_data_in, .serial0_transmit, .serial0_receive, .serial0_clock_in,
    .serial0_clock_out, .serial0_clock_oe, .serial1_transmit,
    .serial1_receive, .serial1_clock_in, .serial1_clock_out,
    .serial1_clock_oe, .timer_output, .timer_clock_input, .timer_input);

  pfs_pin_env i_env (.pad_out, .pad_oe, .ext_level, .pad_in);

  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic cmp(input logic [55:0] got, exp, input string what);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  task automatic wr(input logic [29:0] ix, input logic [7:0] d,
                    input logic s, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= {ix, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= {3'h0, s};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    cmp(n < 40, 1'h1, "write answer");
    cmp(s_axi_bresp, er, "bresp");
  endtask : wr

  task automatic rd(input logic [29:0] ix, input logic [7:0] ed,
                    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_araddr <= {ix, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    cmp(n < 40, 1'h1, "read answer");
    cmp(s_axi_rresp, er, "rresp");
    cmp(s_axi_rdata, {24'h0, ed}, "rdata");
  endtask : rd

  task automatic drive(input logic [55:0] v);
    @(posedge ref_clk);
    port_data_out <= v;
    port_dir <= ~v;
    ext_level <= {v[0], v[55:1]};
    timer_output <= v[20:0];
    {serial1_clock_oe, serial1_clock_out, serial1_transmit} <= v[5:3];
    {serial0_clock_oe, serial0_clock_out, serial0_transmit} <= v[2:0];
  endtask : drive

  task automatic check_pins();
    logic [55:0] s, po, pe, ee, eo, ri;
    s = {shadow[6], shadow[5], shadow[4], shadow[3], shadow[2], shadow[1],
      shadow[0]};
    repeat (6) @(posedge ref_clk);
    #1;
    po = 56'h0;
    pe = 56'h0;
    {po[7], po[5], po[4], po[2]} = {serial1_clock_out, serial1_transmit,
      serial0_clock_out, serial0_transmit};
    {pe[7], pe[5], pe[4], pe[2]} = {serial1_clock_oe, 1'h1,
      serial0_clock_oe, 1'h1};
    po[15:11] = timer_output[20:16];
    po[23:16] = timer_output[15:8];
    po[31:24] = timer_output[7:0];
    pe[31:11] = 21'h1fffff;
    ee = ((port_dir & ~s) | (pe & s)) & IMPL_MASK;
    eo = (port_data_out & ~s) | (po & s);
    ri = pad_in & s;
    cmp(pad_oe, ee, "pad_oe");
    cmp(pad_out & ee, eo & ee, "pad_out");
    cmp({serial1_clock_in, serial1_receive, serial0_clock_in,
      serial0_receive}, {ri[7], ri[6], ri[4], ri[3]}, "serial in");
    cmp(timer_clock_input, ri[39:36], "timer clock");
    cmp(timer_input, {ri[47:40], 12'h0, ri[51], 2'h0, ri[48]},
      "timer in");
    cmp(port_data_in & IMPL_MASK, pad_in & IMPL_MASK, "port in");
  endtask : check_pins

  task automatic t_reset_values();
    for (int g = 0; g < 7; g++) rd(RIDX[g], SEL_RESET, RESP_OKAY);
    check_pins();
  endtask : t_reset_values

  task automatic t_unmapped();
    wr(30'h0080074e, 8'hff, 1'h1, RESP_SLVERR);
    rd(30'h0080074e, 8'h00, RESP_SLVERR);
    rd(30'h00800747, 8'h00, RESP_SLVERR);
  endtask : t_unmapped

  task automatic t_select_all();
    for (int g = 0; g < 7; g++) wr(RIDX[g], 8'hff, 1'h1, RESP_OKAY);
    for (int g = 0; g < 7; g++) begin
      shadow[g] = IMPL_MASK[8*g +: 8];
      rd(RIDX[g], shadow[g], RESP_OKAY);
    end
    check_pins();
    drive(~PAT);
    check_pins();
    wr(RIDX[2], 8'h00, 1'h0, RESP_OKAY);
    rd(RIDX[2], 8'hff, RESP_OKAY);
  endtask : t_select_all

  task automatic t_switch();
    for (int g = 0; g < 7; g++) begin
      wr(RIDX[g], 8'h00, 1'h1, RESP_OKAY);
      shadow[g] = 8'h00;
    end
    check_pins();
    cmp(pad_oe[2], 1'h0, "oe before switch");
    wr(RIDX[0], 8'h04, 1'h1, RESP_OKAY);
    #1;
    cmp(pad_oe[2], 1'h1, "oe after switch");
    cmp(pad_out[2], serial0_transmit, "out after switch");
    shadow[0] = 8'h04;
    check_pins();
  endtask : t_switch

  initial begin
    rst = 1'h1;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_awprot} = '0;
    {s_axi_arprot, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    port_data_out = PAT;
    port_dir = ~PAT;
    ext_level = PAT;
    timer_output = PAT[20:0];
    {serial1_clock_oe, serial1_clock_out, serial1_transmit} = PAT[5:3];
    {serial0_clock_oe, serial0_clock_out, serial0_transmit} = PAT[2:0];
    for (int g = 0; g < 7; g++) shadow[g] = SEL_RESET;
    repeat (16) @(posedge ref_clk);
    rst <= 1'h0;
    t_reset_values();
    t_unmapped();
    t_select_all();
    t_switch();
    results();
  end

  initial begin
    #200000;
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end
endmodule : test_pfs_top
